//--- hw/wtu_top.sv
/*
 * Watchdog timer unit: 17-bit supervision counter with restart codes,
 * test clocking, a two-write disable and an Avalon-MM register slave.
 * Assumes ref_clk (25 MHz) is the peripheral clock and osc_32k comes
 * from the low-speed oscillator pin.
 */
// The Avalon-MM interface to the registers was chosen for this implementation.
// Functional notes
// - counter is seventeen bits wide
// - normal counting from slow oscillator ticks
// - timeout gives one-clock low pulse on pin
// - timeout also pulses processor reset
// - code 5A restarts, two-second period
// - code 57 restarts, one-second period
// - code 59 restarts, 500 ms period
// - code 53 restarts, 250 ms period
// - other restart values change nothing
// - timeout keeps selected period
// - test 51 clocks low byte fast
// - test 52 clocks high byte fast
// - test 53 clocks both bytes fast
// - 54 right after 51-53 disables
// - lone 54 does not disable
// - any other test write re-enables
// - other test values mean normal clocking
`timescale 1ns/1ps
`default_nettype none

module wtu_top
    import wtu_pkg::*;
#(
    parameter int OSC_HZ = WTU_OSC_HZ // shorten for simulation
) (
    input wire logic ref_clk, // 25 MHz peripheral clock
    input wire logic rst_b, // sync reset, active low
    input wire logic osc_32k, // slow oscillator pin
    input wire logic [WTU_ADDR_W-1:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    output logic supervision_out_b, // watchdog pin, low pulse
    output logic cpu_rst // processor reset pulse
);

    localparam logic [WTU_CNT_W-1:0] LIM_2S =
        WTU_CNT_W'(OSC_HZ * WTU_T2S_MS / WTU_MS_PER_S);
    localparam logic [WTU_CNT_W-1:0] LIM_1S =
        WTU_CNT_W'(OSC_HZ * WTU_T1S_MS / WTU_MS_PER_S);
    localparam logic [WTU_CNT_W-1:0] LIM_500 =
        WTU_CNT_W'(OSC_HZ * WTU_T500_MS / WTU_MS_PER_S);
    localparam logic [WTU_CNT_W-1:0] LIM_250 =
        WTU_CNT_W'(OSC_HZ * WTU_T250_MS / WTU_MS_PER_S);
    localparam int HI_W = WTU_CNT_W - WTU_LO_W;

    // ==========================================================
    // functions
    function automatic logic idx_hit(input logic [WTU_ADDR_W-1:0] a,
                                     input logic [5:0] idx);
        idx_hit = (a[WTU_ADDR_W-1:2] == idx) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic hit_valid(input logic [7:0] c);
        hit_valid = (c == WTU_HIT_2S) || (c == WTU_HIT_1S) ||
                    (c == WTU_HIT_500MS) || (c == WTU_HIT_250MS);
    endfunction

    function automatic wtu_period_t hit_period(input logic [7:0] c);
        case (c)
            WTU_HIT_1S: hit_period = WTU_PER_1S;
            WTU_HIT_500MS: hit_period = WTU_PER_500MS;
            WTU_HIT_250MS: hit_period = WTU_PER_250MS;
            default: hit_period = WTU_PER_2S;
        endcase
    endfunction

    function automatic logic [WTU_CNT_W-1:0] limit_of(input wtu_period_t p);
        case (p)
            WTU_PER_1S: limit_of = LIM_1S;
            WTU_PER_500MS: limit_of = LIM_500;
            WTU_PER_250MS: limit_of = LIM_250;
            default: limit_of = LIM_2S;
        endcase
    endfunction

    function automatic logic is_test_clk(input logic [7:0] c);
        is_test_clk = (c == WTU_TST_LOW) || (c == WTU_TST_HIGH) ||
                      (c == WTU_TST_BOTH);
    endfunction

    // ==========================================================
    // oscillator tick
    logic tick;

    wtu_osc_sync u_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .osc_in(osc_32k),
        .tick(tick)
    );

    // ==========================================================
    // bus slave: waitrequest drops one cycle after a request
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic req, go_wr, wr_ctl, wr_tst;
    logic [7:0] wbyte;

    logic [WTU_CNT_W-1:0] cnt_q, cnt_d;
    wtu_period_t per_q, per_d;
    wtu_clkmode_t mode_q, mode_d;
    logic arm_q, arm_d, dis_q, dis_d, seen_q, seen_d;
    logic out_b_q, out_b_d, rst_q, rst_d;

    assign req = avs_read || avs_write;
    assign go_wr = avs_write && !wait_q && avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];
    assign wr_ctl = go_wr && idx_hit(avs_address, WTU_IDX_RESTART);
    assign wr_tst = go_wr && idx_hit(avs_address, WTU_IDX_TEST);

    always_comb begin
        wait_d = !(req && wait_q);
        rdata_d = rdata_q;
        if (avs_read && wait_q) begin
            // write-only registers and holes read as zero
            rdata_d = 32'h0000_0000;
            if (idx_hit(avs_address, WTU_IDX_STATUS)) begin
                rdata_d[WTU_ST_DIS] = dis_q;
                rdata_d[WTU_ST_MODE +: 2] = mode_q;
                rdata_d[WTU_ST_PER +: 2] = per_q;
                rdata_d[WTU_ST_ARM] = arm_q;
                rdata_d[WTU_ST_SEEN] = seen_q;
            end else if (idx_hit(avs_address, WTU_IDX_COUNT)) begin
                rdata_d[WTU_CNT_W-1:0] = cnt_q;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // configuration: period, clock mode, disable sequence
    always_comb begin
        per_d = per_q;
        mode_d = mode_q;
        arm_d = arm_q;
        dis_d = dis_q;
        if (wr_ctl && hit_valid(wbyte)) begin
            per_d = hit_period(wbyte);
        end
        if (wr_tst) begin
            arm_d = is_test_clk(wbyte);
            case (wbyte)
                WTU_TST_LOW: mode_d = WTU_CLK_LOW;
                WTU_TST_HIGH: mode_d = WTU_CLK_HIGH;
                WTU_TST_BOTH: mode_d = WTU_CLK_BOTH;
                default: mode_d = WTU_CLK_NORMAL;
            endcase
            if (wbyte == WTU_TST_OFF) begin
                // a lone 54 neither disables nor re-enables
                if (arm_q) begin
                    dis_d = 1'b1;
                end
            end else begin
                dis_d = 1'b0;
            end
        end
    end

    // period reset only here, never by a timeout
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            per_q <= WTU_PER_RST;
            mode_q <= WTU_CLK_NORMAL;
            arm_q <= 1'b0;
            dis_q <= 1'b0;
        end else begin
            per_q <= per_d;
            mode_q <= mode_d;
            arm_q <= arm_d;
            dis_q <= dis_d;
        end
    end

    // ==========================================================
    // supervision counter
    logic lo_inc, hi_inc, carry, timeout;
    logic [WTU_LO_W-1:0] lo_n;
    logic [HI_W-1:0] hi_n;
    logic [WTU_CNT_W-1:0] cnt_n;

    always_comb begin
        // test modes trade realism for a fast run to timeout
        lo_inc = !dis_q && ((mode_q == WTU_CLK_LOW) ||
                 (mode_q == WTU_CLK_BOTH) || tick);
        if ((mode_q == WTU_CLK_LOW) || (mode_q == WTU_CLK_BOTH)) begin
            lo_inc = !dis_q;
        end
        carry = lo_inc && (cnt_q[WTU_LO_W-1:0] == 8'hFF);
        hi_inc = !dis_q && ((mode_q == WTU_CLK_HIGH) ||
                 (mode_q == WTU_CLK_BOTH) || carry);
        if (mode_q == WTU_CLK_HIGH || mode_q == WTU_CLK_BOTH) begin
            hi_inc = !dis_q;
        end
        lo_n = cnt_q[WTU_LO_W-1:0] + WTU_LO_W'(lo_inc);
        hi_n = cnt_q[WTU_CNT_W-1:WTU_LO_W] + HI_W'(hi_inc);
        cnt_n = {hi_n, lo_n};
        // compare as a crossing: the high byte steps by 256 in the high and both test modes
        timeout = (lo_inc || hi_inc) && (cnt_n >= limit_of(per_q));
        cnt_d = cnt_n;
        out_b_d = 1'b1;
        rst_d = 1'b0;
        seen_d = seen_q;
        if (wr_ctl && hit_valid(wbyte)) begin
            // a restart in the timeout cycle wins
            cnt_d = '0;
        end else if (wr_ctl) begin
            cnt_d = cnt_n;
        end
        if (!(wr_ctl && hit_valid(wbyte)) && timeout) begin
            cnt_d = '0;
            out_b_d = 1'b0;
            rst_d = 1'b1;
            seen_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cnt_q <= '0;
            out_b_q <= 1'b1;
            rst_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_b_q <= out_b_d;
            rst_q <= rst_d;
            seen_q <= seen_d;
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign supervision_out_b = out_b_q;
    assign cpu_rst = rst_q;

    // ==========================================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    logic hit_ok;
    assign hit_ok = wr_ctl && hit_valid(wbyte);

    AST_CNT_BOUND: assert property (
        cnt_q <= limit_of(per_q))
        else $error("counter beyond selected limit");

    AST_SLOW_HOLD: assert property (
        mode_q == WTU_CLK_NORMAL && !tick && !hit_ok && !dis_q
        |=> cnt_q == $past(cnt_q))
        else $error("counter moved without oscillator tick");

    AST_PIN_PULSE: assert property (
        timeout && !hit_ok |=> !supervision_out_b ##1 supervision_out_b)
        else $error("watchdog pin pulse not one clock");

    AST_CPU_RST: assert property (
        !supervision_out_b |-> cpu_rst)
        else $error("processor reset missing on timeout");

    AST_RESTART: assert property (
        hit_ok |=> cnt_q == '0 && per_q == hit_period($past(wbyte)))
        else $error("restart code did not restart");

    AST_BAD_CODE: assert property (
        wr_ctl && !hit_valid(wbyte) |=> $stable(per_q))
        else $error("invalid code changed period");

    AST_KEEP_PER: assert property (
        cpu_rst |-> per_q == $past(per_q, 2))
        else $error("timeout changed period");

    AST_FAST_LOW: assert property (
        (mode_q == WTU_CLK_LOW || mode_q == WTU_CLK_BOTH) && !dis_q &&
        !hit_ok && !timeout
        |=> cnt_q[7:0] == $past(cnt_q[7:0]) + 8'h01)
        else $error("low byte not on fast clock");

    AST_FAST_HIGH: assert property (
        wr_tst && wbyte == WTU_TST_HIGH |=> mode_q == WTU_CLK_HIGH)
        else $error("high byte test mode not taken");

    AST_DISABLE: assert property (
        wr_tst && wbyte == WTU_TST_OFF && arm_q |=> dis_q ##1 !cpu_rst)
        else $error("armed disable failed");

    AST_NO_DISABLE: assert property (
        wr_tst && wbyte == WTU_TST_OFF && !arm_q && !dis_q |=> !dis_q)
        else $error("lone disable code took effect");

    AST_REENABLE: assert property (
        wr_tst && wbyte != WTU_TST_OFF && !is_test_clk(wbyte)
        |=> !dis_q && mode_q == WTU_CLK_NORMAL)
        else $error("other test write did not re-enable");

    AST_PER_STABLE: assert property (
        !hit_ok |=> $stable(per_q))
        else $error("period changed without restart");

    AST_SLOW_STEP: assert property (
        mode_q == WTU_CLK_NORMAL && tick && !dis_q && !hit_ok && !timeout
        |=> cnt_q == $past(cnt_q) + 17'h0_0001)
        else $error("counter missed oscillator tick");

    AST_FAST_HIGH_STEP: assert property (
        (mode_q == WTU_CLK_HIGH || mode_q == WTU_CLK_BOTH) && !dis_q &&
        !hit_ok && !timeout
        |=> cnt_q[16:8] == $past(cnt_q[16:8]) + 9'h001)
        else $error("high byte not on fast clock");

    AST_FROZEN: assert property (
        dis_q && !hit_ok |=> cnt_q == $past(cnt_q) && supervision_out_b)
        else $error("disabled counter moved");

    CV_TIMEOUT: cover property (!supervision_out_b);
    CV_DISABLE: cover property (wr_tst ##[1:40] wr_tst && dis_d);
    CV_RESTART_250: cover property (hit_ok && wbyte == WTU_HIT_250MS);
    CV_FAST_BOTH: cover property (mode_q == WTU_CLK_BOTH && timeout);
    CV_HIT_WINS: cover property (hit_ok && timeout);

endmodule // wtu_top

`default_nettype wire

//--- hw/wtu_pkg.sv
/*
 * Constants and types shared by the watchdog timer unit.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package wtu_pkg;

    // ==========================================================
    // register indices (byte address = index * 4)
    localparam logic [5:0] WTU_IDX_RESTART = 6'h08;
    localparam logic [5:0] WTU_IDX_TEST = 6'h09;
    localparam logic [5:0] WTU_IDX_STATUS = 6'h0A;
    localparam logic [5:0] WTU_IDX_COUNT = 6'h0B;
    localparam int WTU_ADDR_W = 8;

    // ==========================================================
    // restart and test codes
    localparam logic [7:0] WTU_HIT_2S = 8'h5A;
    localparam logic [7:0] WTU_HIT_1S = 8'h57;
    localparam logic [7:0] WTU_HIT_500MS = 8'h59;
    localparam logic [7:0] WTU_HIT_250MS = 8'h53;
    localparam logic [7:0] WTU_TST_LOW = 8'h51;
    localparam logic [7:0] WTU_TST_HIGH = 8'h52;
    localparam logic [7:0] WTU_TST_BOTH = 8'h53;
    localparam logic [7:0] WTU_TST_OFF = 8'h54;

    // ==========================================================
    // counter and timing
    localparam int WTU_CNT_W = 17;
    localparam int WTU_LO_W = 8;
    localparam int WTU_OSC_HZ = 32768;
    localparam int WTU_T2S_MS = 2000;
    localparam int WTU_T1S_MS = 1000;
    localparam int WTU_T500_MS = 500;
    localparam int WTU_T250_MS = 250;
    localparam int WTU_MS_PER_S = 1000;

    // ==========================================================
    // status word field positions
    localparam int WTU_ST_DIS = 0;
    localparam int WTU_ST_MODE = 1;
    localparam int WTU_ST_PER = 3;
    localparam int WTU_ST_ARM = 5;
    localparam int WTU_ST_SEEN = 6;

    typedef enum logic [1:0] {
        WTU_PER_2S,
        WTU_PER_1S,
        WTU_PER_500MS,
        WTU_PER_250MS
    } wtu_period_t;

    typedef enum logic [1:0] {
        WTU_CLK_NORMAL,
        WTU_CLK_LOW,
        WTU_CLK_HIGH,
        WTU_CLK_BOTH
    } wtu_clkmode_t;

    localparam wtu_period_t WTU_PER_RST = WTU_PER_2S;

endpackage

//--- hw/wtu_osc_sync.sv
/*
 * Brings the slow oscillator pin into the ref_clk domain and gives a
 * one-cycle tick per rising edge.
 * Assumes the oscillator is far slower than ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module wtu_osc_sync (
    input wire logic ref_clk, // system clock
    input wire logic rst_b, // sync reset, active low
    input wire logic osc_in, // raw oscillator pin
    output logic tick // one pulse per oscillator rise
);

    // ==========================================================
    // three-stage capture
    logic s1_q, s2_q, s3_q, lvl_q, tick_q;
    logic s1_d, s2_d, s3_d, lvl_d, tick_d;

    always_comb begin
        s1_d = osc_in;
        s2_d = s1_q;
        s3_d = s2_q;
        lvl_d = lvl_q;
        tick_d = 1'b0;
        // a change counts only once stages two and three agree
        if (s2_q == s3_q) begin
            lvl_d = s3_q;
            tick_d = s3_q && !lvl_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            lvl_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            lvl_q <= lvl_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

endmodule // wtu_osc_sync

`default_nettype wire

//--- sim/tb_wtu_top.sv
/*
 * Self-checking bench for the watchdog timer unit: register access, test
 * clocking, restart codes, timeouts, the two-write disable and reset.
 * Assumes wtu_pkg and wtu_top are compiled first; OSC_HZ is shortened.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_wtu_top;
    import wtu_pkg::*;

    localparam int OSC = 2048; // limits 4096/2048/1024/512, all above one high step
    localparam logic [7:0] A_RST = 8'h20;
    localparam logic [7:0] A_TST = 8'h24;
    localparam logic [7:0] A_ST = 8'h28;
    localparam logic [7:0] A_CNT = 8'h2C;
    localparam logic [7:0] A_BAD = 8'h30;

    logic ref_clk, rst_b, osc_32k, osc_run, avs_read, avs_write;
    logic avs_waitrequest, supervision_out_b, cpu_rst, last_rst;
    logic [WTU_ADDR_W-1:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, v, c1, c2;
    logic [3:0] avs_byteenable;
    logic [7:0] codes [4];
    int err_total, n_compared, n, lim;

    wtu_top #(.OSC_HZ(OSC)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .osc_32k(osc_32k),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .supervision_out_b(supervision_out_b), .cpu_rst(cpu_rst)
    );

    // ==========================================================
    // clock, slow oscillator, pulse monitor
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // oscillator stands low while not wanted, rises every 20 clocks
    initial begin
        osc_32k = 1'b0;
        forever begin
            repeat (10) @(posedge ref_clk);
            osc_32k <= osc_run ? ~osc_32k : 1'b0;
        end
    end

    always @(posedge ref_clk) begin
        last_rst <= cpu_rst;
        if (rst_b === 1'b1) begin
            check({31'h0, supervision_out_b}, {31'h0, ~cpu_rst});
            if (cpu_rst === 1'b1) check({31'h0, last_rst}, 32'h0);
        end
    end

    // ==========================================================
    // helpers
    task automatic tally_and_finish;
        if (err_total == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            err_total++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic bus(input logic wr_en, input logic [7:0] a, input logic [7:0] d,
                       input logic [3:0] be, output logic [31:0] rdat);
        logic [31:0] junk;
        int k;
        junk = $urandom();
        @(posedge ref_clk);
        avs_write <= wr_en;
        avs_read <= ~wr_en;
        avs_address <= a;
        avs_writedata <= {junk[31:8], d};
        avs_byteenable <= be;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        check(32'(k), 32'h2);
        if (k >= 20) begin
            err_total++;
            tally_and_finish();
        end else begin
            rdat = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, 4'hF, dummy);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] rdat);
        bus(1'b0, a, 8'h00, 4'hF, rdat);
    endtask

    // cycles until cpu_rst is seen high, capped
    task automatic wait_pulse(input int cap, output int cnt);
        cnt = 0;
        do begin
            @(posedge ref_clk);
            cnt++;
        end while (cpu_rst !== 1'b1 && cnt < cap);
    endtask

    function automatic int lim_of(input logic [7:0] c);
        case (c)
            WTU_HIT_2S: return OSC * WTU_T2S_MS / WTU_MS_PER_S;
            WTU_HIT_1S: return OSC * WTU_T1S_MS / WTU_MS_PER_S;
            WTU_HIT_500MS: return OSC * WTU_T500_MS / WTU_MS_PER_S;
            default: return OSC * WTU_T250_MS / WTU_MS_PER_S;
        endcase
    endfunction

    // any byte outside 51..5A, so neither a test code nor a restart code
    function automatic logic [7:0] other_val();
        logic [7:0] x;
        do x = 8'($urandom()); while (x >= 8'h51 && x <= 8'h5A);
        return x;
    endfunction

    // ==========================================================
    // main sequence
    initial begin
        rst_b = 1'b0; osc_run = 1'b0; avs_read = 1'b0; avs_write = 1'b0;
        avs_address = 8'h00; avs_writedata = 32'h0; avs_byteenable = 4'hF;
        err_total = 0; n_compared = 0;
        codes = '{WTU_HIT_2S, WTU_HIT_1S, WTU_HIT_500MS, WTU_HIT_250MS};
        void'($urandom(32'hBF89));
        repeat (20) @(posedge ref_clk);
        check({30'h0, supervision_out_b, cpu_rst}, 32'h2);
        rst_b <= 1'b1;
        rd(A_ST, v); check(v, 32'h0);
        rd(A_RST, v); check(v, 32'h0);
        rd(A_BAD, v); check(v, 32'h0);
        rd(A_CNT, c1); repeat (30) @(posedge ref_clk);
        rd(A_CNT, c2); check(c2, c1);
        // test clocking modes count on the fast clock
        for (int m = 1; m < 4; m++) begin
            wr(A_TST, 8'(8'h50 + m));
            rd(A_ST, v); check(v & 32'h3F, 32'((1 << 5) | (m << 1)));
            rd(A_CNT, c1); rd(A_CNT, c2);
            check({31'h0, c2 !== c1}, 32'h1);
            check(c2 >> WTU_CNT_W, 32'h0);
        end
        wr(A_TST, other_val());
        rd(A_ST, v); check(v & 32'h3F, 32'h0);
        // each restart code in fast low-byte mode, timeout distance within two cycles of the limit
        foreach (codes[i]) begin
            wr(A_TST, WTU_TST_LOW);
            wr(A_RST, codes[i]);
            lim = lim_of(codes[i]);
            wait_pulse(5000, n);
            check({31'h0, n >= lim && n <= lim + 2}, 32'h1);
            rd(A_ST, v); check((v >> WTU_ST_PER) & 32'h3, 32'(i));
            check((v >> WTU_ST_SEEN) & 32'h1, 32'h1);
        end
        // non-codes and masked lanes leave counter and period alone
        wr(A_RST, WTU_HIT_2S);
        repeat (5) begin
            rd(A_CNT, c1);
            wr(A_RST, other_val());
            rd(A_CNT, c2); check({31'h0, c2 > c1}, 32'h1);
        end
        bus(1'b1, A_RST, WTU_HIT_250MS, 4'hE, v);
        rd(A_CNT, c1); check({31'h0, c1 > c2}, 32'h1);
        rd(A_ST, v); check((v >> WTU_ST_PER) & 32'h3, 32'h0);
        wr(A_RST, WTU_HIT_1S);
        rd(A_CNT, c1); check({31'h0, c1 < 8}, 32'h1);
        // disable sequence
        wr(A_TST, 8'h00); wr(A_TST, WTU_TST_OFF);
        rd(A_ST, v); check(v & 32'h1, 32'h0);
        for (int m = 1; m < 4; m++) begin
            wr(A_TST, 8'(8'h50 + m));
            wr(A_RST, WTU_HIT_250MS);
            wr(A_TST, WTU_TST_OFF);
            rd(A_ST, v); check(v & 32'h1, 32'h1);
            wr(A_TST, other_val());
            rd(A_ST, v); check(v & 32'h1, 32'h0);
        end
        wr(A_TST, WTU_TST_BOTH); wr(A_TST, WTU_TST_OFF);
        osc_run = 1'b1;
        rd(A_CNT, c1);
        wait_pulse(700, n); check(n, 32'd700);
        rd(A_CNT, c2); check(c2, c1);
        // normal oscillator clocking, 250 ms timeout in slow ticks
        wr(A_TST, 8'h00);
        wr(A_RST, WTU_HIT_250MS);
        wait_pulse(12000, n);
        lim = lim_of(WTU_HIT_250MS) * 20;
        check({31'h0, n >= lim - 25 && n <= lim + 25}, 32'h1);
        rd(A_ST, v); check((v >> WTU_ST_PER) & 32'h3, 32'h3);
        // second reset restores defaults
        osc_run = 1'b0;
        rst_b <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(A_ST, v); check(v, 32'h0);
        tally_and_finish();
    end

endmodule // tb_wtu_top

`default_nettype wire
